/* File: hw/rfid_cfg_map.svh */
// Address map, field positions, reset values and codes of the tag configuration logic.
// Assumes value bit 15 is the word's first (lowest addressed) bit on the air.
`ifndef RFID_CFG_MAP_SVH
`define RFID_CFG_MAP_SVH
// ----------------------------------------
// Word addresses in the EPC bank and the toggle command opcode
// ----------------------------------------
`define CFG_ADDR        16'h0200
`define MPART_ADDR      16'h01f0
`define TOGGLE_OPCODE   16'he007
// ----------------------------------------
// Feature word layout
// ----------------------------------------
`define CFG_TAMPER_BIT  15
`define CFG_EXTSUP_BIT  14
`define CFG_INVOUT_BIT  11
`define CFG_TRANSP_BIT  10
`define CFG_DATAMD_BIT  9
`define CFG_CRRR_BIT    8
`define CFG_CRSHORT_BIT 7
`define CFG_MAXBS_BIT   6
`define CFG_DIGOUT_BIT  5
`define CFG_RRR_BIT     4
`define CFG_UMPROT_BIT  3
`define CFG_EPCPROT_BIT 2
`define CFG_TIDPROT_BIT 1
`define CFG_PSF_BIT     0
`define CFG_IND_MASK    16'hc000
`define CFG_RFU_MASK    16'h3000
`define CFG_TEMP_MASK   16'h0e00
`define CFG_PERM_MASK   16'h01ff
`define CFG_RESET       16'h0000
// ----------------------------------------
// Partition word layout
// ----------------------------------------
`define MP_RFU_MASK     16'hf000
`define MP_EPC_LSB      8
`define MP_PROT_LSB     4
`define MP_PRIV_LSB     0
`define MP_RESET        16'h0000
`define TOTAL_BLOCKS    6'd10
`define MAX_EPC_BLOCKS  4'd5
`define BASE_EPC_BITS   9'd128
`define BLOCK_SHIFT     6
// ----------------------------------------
// CRC-16 and error codes
// ----------------------------------------
`define CRC_PRESET      16'hffff
`define CRC_POLY        16'h1021
`define CRC_RESIDUE     16'h1d0f
`define ERR_MEM_LOCKED  8'h04
`define ERR_NONSPEC     8'h0f
`endif

/* File: hw/rfid_cfg_pkg.sv */
// Types shared by the tag configuration logic and its surroundings.
// Assumes the air front end delivers parsed command fields.
package rfid_cfg_pkg;
  typedef enum logic [2:0] {
    TAG_READY, TAG_ARBITRATE, TAG_REPLY, TAG_ACKNOWLEDGED,
    TAG_OPEN, TAG_SECURED, TAG_KILLED
  } tag_state_t;
  typedef struct packed {
    logic        valid;
    logic [15:0] opcode;
    logic [7:0]  rfu;
    logic [15:0] maskXor;
    logic [15:0] handle;
    logic [15:0] crc;
  } toggle_cmd_t;
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
    logic [15:0] data;
  } mem_req_t;
  typedef struct packed {
    logic        valid;
    logic        hit;
    logic        error;
    logic [7:0]  errCode;
    logic [15:0] data;
  } mem_rsp_t;
  typedef struct packed {
    logic        valid;
    logic        isError;
    logic [7:0]  errCode;
    logic [15:0] word;
    logic [15:0] handle;
    logic [15:0] crc;
    logic        extPreamble;
  } reply_t;
  typedef struct packed {
    logic [15:0] cfgPerm;
    logic [15:0] memPart;
    logic        memPartLocked;
  } nvm_image_t;
  typedef struct packed {
    logic        req;
    logic [15:0] addr;
    logic [15:0] data;
  } nvm_wr_t;
endpackage

/* File: hw/rfid_tag_feature_config_control.sv */
// Feature word, partition word and the toggle command of a passive UHF tag.
// Assumes a front end that parses commands, serialises replies and owns NVM timing.
`timescale 1ns/1ps
`include "rfid_cfg_map.svh"

module rfid_tag_feature_config_control (
  // Clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      arst_n,
  // Protocol context
  input  wire rfid_cfg_pkg::tag_state_t  tagState,
  input  wire logic [15:0]               sessionHandle,
  input  wire logic [15:0]               rn16,
  input  wire logic                      accessPwZero,
  input  wire logic                      frameSyncSeen,
  input  wire logic                      reqRnSeen,
  input  wire logic                      epcBankLocked,
  input  wire logic                      memLockEvent,
  // Parsed commands
  input  wire rfid_cfg_pkg::toggle_cmd_t toggleCmd,
  input  wire rfid_cfg_pkg::mem_req_t    memReq,
  // Sensed pins
  input  wire logic                      tamperPin,
  input  wire logic                      extSupplyPin,
  // Non-volatile store
  input  wire rfid_cfg_pkg::nvm_image_t  nvmImage,
  output rfid_cfg_pkg::nvm_wr_t          nvmWr,
  input  wire logic                      nvmDone,
  input  wire logic                      nvmFail,
  // Answers
  output rfid_cfg_pkg::reply_t           reply,
  output rfid_cfg_pkg::mem_rsp_t         memRsp,
  output logic                           busy,
  // Feature state
  output logic [15:0]                    cfgWord,
  output logic [15:0]                    memPartWord,
  output logic [8:0]                     epcBits,
  output logic [3:0]                     openBlocks
);
  import rfid_cfg_pkg::*;

  // ----------------------------------------
  // CRC-16, bits taken MSB first
  // ----------------------------------------
  function automatic logic [15:0] crc16Calc(input logic [87:0] bits, input int n);
    logic [15:0] c;
    c = `CRC_PRESET;
    for (int i = 0; i < 88; i++) begin
      if (i < n) begin
        if (c[15] ^ bits[87-i]) c = {c[14:0], 1'b0} ^ `CRC_POLY;
        else c = {c[14:0], 1'b0};
      end
    end
    return c;
  endfunction

  typedef enum logic [1:0] {ST_LOAD, ST_IDLE, ST_COMMIT} fsm_t;

  fsm_t        state_reg, state_next;
  logic [11:0] cfg_reg, cfg_next;
  logic [15:0] mp_reg, mp_next;
  logic        mpLock_reg, mpLock_next;
  logic [1:0]  ind_reg, ind_next;
  logic [15:0] pend_reg, pend_next;
  logic        pendToggle_reg, pendToggle_next;
  logic        pendMp_reg, pendMp_next;
  logic [15:0] pendHandle_reg, pendHandle_next;
  nvm_wr_t     nvm_reg, nvm_next;
  reply_t      reply_reg, reply_next;
  mem_rsp_t    rsp_reg, rsp_next;

  logic [15:0] curWord;
  logic [15:0] mask;
  logic [15:0] toggled;
  logic [15:0] wrCfg;
  logic [15:0] wrMp;
  logic [5:0]  blkSum;
  logic        cmdOk;
  logic        partOk;

  // ----------------------------------------
  // Combinational decode
  // ----------------------------------------
  always_comb begin
    curWord = {ind_reg, 2'b00, cfg_reg};
    mask = toggleCmd.maskXor ^ rn16;
    // Frame is left-aligned so the padding behind the CRC is never clocked in
    cmdOk = toggleCmd.valid && (toggleCmd.opcode == `TOGGLE_OPCODE)
      && ((tagState == TAG_OPEN) || (tagState == TAG_SECURED))
      && (crc16Calc({toggleCmd.opcode, toggleCmd.rfu, toggleCmd.maskXor,
                     toggleCmd.handle, toggleCmd.crc, 16'h0000}, 72) == `CRC_RESIDUE)
      && (toggleCmd.handle == sessionHandle)
      && frameSyncSeen && reqRnSeen
      && ((mask & `CFG_RFU_MASK) == 16'h0000);
    if ((tagState == TAG_OPEN) || accessPwZero) mask = 16'h0000;
    mask = mask & (`CFG_TEMP_MASK | `CFG_PERM_MASK);
    toggled = curWord ^ mask;
    wrCfg = (curWord & (`CFG_IND_MASK | `CFG_RFU_MASK))
      | (memReq.data & (`CFG_TEMP_MASK | `CFG_PERM_MASK));
    wrMp = memReq.data & ~`MP_RFU_MASK;
    blkSum = {2'b00, wrMp[`MP_EPC_LSB +: 4]} + {2'b00, wrMp[`MP_PROT_LSB +: 4]}
      + {2'b00, wrMp[`MP_PRIV_LSB +: 4]};
    partOk = (blkSum <= `TOTAL_BLOCKS)
      && (wrMp[`MP_EPC_LSB +: 4] <= `MAX_EPC_BLOCKS);
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    state_next      = state_reg;
    cfg_next        = cfg_reg;
    mp_next         = mp_reg;
    mpLock_next     = mpLock_reg | memLockEvent;
    ind_next        = {tamperPin, extSupplyPin};
    pend_next       = pend_reg;
    pendToggle_next = pendToggle_reg;
    pendMp_next     = pendMp_reg;
    pendHandle_next = pendHandle_reg;
    nvm_next        = nvm_reg;
    nvm_next.req    = 1'b0;
    reply_next      = reply_reg;
    reply_next.valid = 1'b0;
    rsp_next        = rsp_reg;
    rsp_next.valid  = 1'b0;
    unique case (state_reg)
      ST_LOAD: begin
        // Temporary bits come up cleared; only the NVM bits are restored
        cfg_next = 12'(nvmImage.cfgPerm & `CFG_PERM_MASK);
        mp_next = nvmImage.memPart & ~`MP_RFU_MASK;
        mpLock_next = nvmImage.memPartLocked | memLockEvent;
        state_next = ST_IDLE;
      end
      ST_IDLE: begin
        if (cmdOk) begin
          if (((toggled ^ curWord) & `CFG_PERM_MASK) != 16'h0000) begin
            nvm_next.req = 1'b1;
            nvm_next.addr = `CFG_ADDR;
            nvm_next.data = toggled & `CFG_PERM_MASK;
            pend_next = toggled;
            pendToggle_next = 1'b1;
            pendMp_next = 1'b0;
            pendHandle_next = toggleCmd.handle;
            state_next = ST_COMMIT;
          end else begin
            cfg_next = toggled[11:0];
            reply_next.valid = 1'b1;
            reply_next.isError = 1'b0;
            reply_next.errCode = 8'h00;
            reply_next.word = toggled;
            reply_next.handle = toggleCmd.handle;
            reply_next.crc = ~crc16Calc({1'b0, toggled, toggleCmd.handle, 55'h0}, 33);
            reply_next.extPreamble = 1'b1;
          end
        end else if (memReq.valid) begin
          rsp_next.valid = 1'b1;
          rsp_next.error = 1'b0;
          rsp_next.errCode = 8'h00;
          rsp_next.hit = (memReq.addr == `CFG_ADDR) || (memReq.addr == `MPART_ADDR);
          rsp_next.data = 16'h0000;
          if (!memReq.write) begin
            if (memReq.addr == `CFG_ADDR) rsp_next.data = curWord;
            if (memReq.addr == `MPART_ADDR) rsp_next.data = mp_reg;
          end else if (memReq.addr == `CFG_ADDR) begin
            if (epcBankLocked) begin
              rsp_next.error = 1'b1;
              rsp_next.errCode = `ERR_MEM_LOCKED;
            end else if (((wrCfg ^ curWord) & `CFG_PERM_MASK) != 16'h0000) begin
              rsp_next.valid = 1'b0;
              nvm_next.req = 1'b1;
              nvm_next.addr = `CFG_ADDR;
              nvm_next.data = wrCfg & `CFG_PERM_MASK;
              pend_next = wrCfg;
              pendToggle_next = 1'b0;
              pendMp_next = 1'b0;
              state_next = ST_COMMIT;
            end else begin
              cfg_next = wrCfg[11:0];
            end
          end else if (memReq.addr == `MPART_ADDR) begin
            if (mpLock_reg || (tagState != TAG_SECURED) || !partOk) begin
              rsp_next.error = 1'b1;
              rsp_next.errCode = `ERR_MEM_LOCKED;
            end else begin
              rsp_next.valid = 1'b0;
              nvm_next.req = 1'b1;
              nvm_next.addr = `MPART_ADDR;
              nvm_next.data = wrMp;
              pend_next = wrMp;
              pendToggle_next = 1'b0;
              pendMp_next = 1'b1;
              state_next = ST_COMMIT;
            end
          end
        end
      end
      ST_COMMIT: begin
        // Waiting keeps the reply behind the NVM write; the reader's CW covers it
        if (nvmDone || nvmFail) begin
          state_next = ST_IDLE;
          if (nvmDone && !nvmFail) begin
            if (pendMp_reg) begin
              mp_next = pend_reg;
              mpLock_next = 1'b1;
            end else begin
              cfg_next = pend_reg[11:0];
            end
          end
          if (pendToggle_reg) begin
            reply_next.valid = 1'b1;
            reply_next.isError = nvmFail;
            reply_next.errCode = nvmFail ? `ERR_NONSPEC : 8'h00;
            reply_next.word = nvmFail ? curWord : {ind_reg, 2'b00, pend_reg[11:0]};
            reply_next.handle = pendHandle_reg;
            reply_next.crc = ~crc16Calc({1'b0, ind_reg, 2'b00, pend_reg[11:0],
                                         pendHandle_reg, 55'h0}, 33);
            reply_next.extPreamble = 1'b1;
          end else begin
            rsp_next.valid = 1'b1;
            rsp_next.hit = 1'b1;
            rsp_next.error = nvmFail;
            rsp_next.errCode = nvmFail ? `ERR_NONSPEC : 8'h00;
            rsp_next.data = 16'h0000;
          end
        end
      end
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_reg      <= ST_LOAD;
      cfg_reg        <= 12'(`CFG_RESET);
      mp_reg         <= `MP_RESET;
      mpLock_reg     <= 1'b0;
      ind_reg        <= 2'b00;
      pend_reg       <= 16'h0000;
      pendToggle_reg <= 1'b0;
      pendMp_reg     <= 1'b0;
      pendHandle_reg <= 16'h0000;
      nvm_reg        <= '0;
      reply_reg      <= '0;
      rsp_reg        <= '0;
    end else begin
      state_reg      <= state_next;
      cfg_reg        <= cfg_next;
      mp_reg         <= mp_next;
      mpLock_reg     <= mpLock_next;
      ind_reg        <= ind_next;
      pend_reg       <= pend_next;
      pendToggle_reg <= pendToggle_next;
      pendMp_reg     <= pendMp_next;
      pendHandle_reg <= pendHandle_next;
      nvm_reg        <= nvm_next;
      reply_reg      <= reply_next;
      rsp_reg        <= rsp_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_comb begin
    nvmWr = nvm_reg;
    reply = reply_reg;
    memRsp = rsp_reg;
    busy = (state_reg != ST_IDLE);
    cfgWord = {ind_reg, 2'b00, cfg_reg};
    memPartWord = mp_reg;
    epcBits = `BASE_EPC_BITS
      + 9'({5'd0, mp_reg[`MP_EPC_LSB +: 4]} << `BLOCK_SHIFT);
    openBlocks = 4'(`TOTAL_BLOCKS - ({2'b00, mp_reg[`MP_EPC_LSB +: 4]}
      + {2'b00, mp_reg[`MP_PROT_LSB +: 4]} + {2'b00, mp_reg[`MP_PRIV_LSB +: 4]}));
  end
endmodule // rfid_tag_feature_config_control

/* File: bench/rfid_reader_model.sv */
// Interrogator side: builds a parsed toggle command with its CRC-16.
// Assumes the bench raises go for one clk_sys cycle per command.
`timescale 1ns/1ps
`include "rfid_cfg_map.svh"
module rfid_reader_model (
  // Request from the bench
  input  wire logic                 go,
  input  wire logic                 badCrc,
  input  wire logic [15:0]          mask,
  input  wire logic [15:0]          rn,
  input  wire logic [15:0]          hnd,
  // Command toward the tag
  output rfid_cfg_pkg::toggle_cmd_t cmd
);
  import rfid_cfg_pkg::*;
  // ----
  // CRC-16, first bit on the air first
  // ----
  function automatic logic [15:0] crc16(logic [87:0] d, int n);
    logic [15:0] c;
    c = `CRC_PRESET;
    for (int i = n - 1; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((d[i] ^ c[15]) ? `CRC_POLY : 16'h0000);
    end
    return c;
  endfunction
  toggle_cmd_t frame;
  // Idle fields show the inverse so a stale command is never mistaken for a live one
  always_comb begin
    frame.valid   = go;
    frame.opcode  = `TOGGLE_OPCODE;
    frame.rfu     = 8'h00;
    frame.maskXor = mask ^ rn;
    frame.handle  = hnd;
    frame.crc     = ~crc16({32'h0, frame.opcode, frame.rfu, frame.maskXor, hnd}, 56)
                    ^ {15'h0, badCrc};
    cmd           = go ? frame : ~frame;
    cmd.valid     = go;
  end
endmodule // rfid_reader_model

/* File: bench/rfid_cfg_assertions.sv */
// Port-level assertions for the feature configuration block.
// Assumes one clock domain, clk_sys, reset by arst_n.
`timescale 1ns/1ps
`include "rfid_cfg_map.svh"
module rfid_cfg_assertions (
  // Clock and reset
  input wire logic                      clk_sys,
  input wire logic                      arst_n,
  // Block inputs
  input wire rfid_cfg_pkg::tag_state_t  tagState,
  input wire logic [15:0]               sessionHandle,
  input wire rfid_cfg_pkg::toggle_cmd_t toggleCmd,
  input wire rfid_cfg_pkg::mem_req_t    memReq,
  input wire logic                      tamperPin,
  input wire logic                      extSupplyPin,
  input wire logic                      nvmDone,
  input wire logic                      nvmFail,
  // Block outputs
  input wire rfid_cfg_pkg::nvm_wr_t     nvmWr,
  input wire rfid_cfg_pkg::reply_t      reply,
  input wire rfid_cfg_pkg::mem_rsp_t    memRsp,
  input wire logic                      busy,
  input wire logic [15:0]               cfgWord,
  input wire logic [15:0]               memPartWord,
  input wire logic [8:0]                epcBits,
  input wire logic [3:0]                openBlocks
);
  import rfid_cfg_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // ----
  // Checks
  // ----
  function automatic logic [4:0] bsum(logic [15:0] w);
    return 5'(w[11:8]) + 5'(w[7:4]) + 5'(w[3:0]);
  endfunction
  logic tgl;
  assign tgl = toggleCmd.valid && !busy;
  a_ind_follow: assert property (cfgWord[15:14] == $past({tamperPin, extSupplyPin}))
    else $error("indicator bits off");
  a_rfu_zero: assert property (cfgWord[13:12] == 2'h0 && memPartWord[15:12] == 4'h0)
    else $error("reserved bits set");
  a_epc_size: assert property (10'(epcBits) == 10'h080 + {memPartWord[11:8], 6'h00})
    else $error("epc size wrong");
  a_open_count: assert property (5'(openBlocks) == 5'h0a - bsum(memPartWord))
    else $error("open block count wrong");
  a_state_gate: assert property (
    tgl && !(tagState inside {TAG_OPEN, TAG_SECURED}) |=> !reply.valid)
    else $error("toggle answered in wrong state");
  a_open_report: assert property (
    tgl && (tagState == TAG_OPEN) |=> $stable(cfgWord[11:0]))
    else $error("open state changed the word");
  a_ext_preamble: assert property (reply.valid && !reply.isError |-> reply.extPreamble)
    else $error("short preamble");
  a_reply_fields: assert property (
    reply.valid && !reply.isError |-> reply.handle == sessionHandle
    && reply.word[13:0] == cfgWord[13:0])
    else $error("reply fields wrong");
  a_commit_wait: assert property (reply.valid && $past(busy) |-> $past(nvmDone || nvmFail))
    else $error("reply before commit end");
  a_busy_commit: assert property (nvmWr.req |-> busy)
    else $error("commit without busy");
  a_commit_end: assert property ((nvmDone || nvmFail) && busy |=> reply.valid || memRsp.valid)
    else $error("no answer after commit");
  a_overbook: assert property (
    memReq.valid && memReq.write && !busy && !toggleCmd.valid && memReq.addr == `MPART_ADDR
    && bsum(memReq.data) > 5'h0a |=> memRsp.valid && memRsp.errCode == `ERR_MEM_LOCKED)
    else $error("over-booked partition accepted");
  c_toggle_ok: cover property (reply.valid && !reply.isError);
  c_commit: cover property (nvmWr.req);
  c_mem_err: cover property (memRsp.valid && memRsp.error);
endmodule // rfid_cfg_assertions
bind rfid_tag_feature_config_control rfid_cfg_assertions chk_u (.*);

/* File: bench/rfid_tag_feature_config_control_test.sv */
// Self-checking bench for the tag feature configuration block.
// Assumes the reader model for commands; NVM commits are answered at once.
`timescale 1ns/1ps
`include "rfid_cfg_map.svh"
module rfid_tag_feature_config_control_test;
  import rfid_cfg_pkg::*;
  logic        clk_sys, arst_n, accessPwZero, frameSyncSeen, reqRnSeen, epcBankLocked;
  logic        tamperPin, extSupplyPin, nvmDone, nvmFail, failCommit, go, badCrc, busy;
  logic [15:0] sessionHandle, rn16, cmdHnd, mask, cfgWord, memPartWord;
  logic [8:0]  epcBits;
  logic [3:0]  openBlocks;
  tag_state_t  tagState;
  toggle_cmd_t toggleCmd;
  mem_req_t    memReq;
  nvm_image_t  nvmImage;
  nvm_wr_t     nvmWr;
  reply_t      reply;
  mem_rsp_t    memRsp;
  int          error_cnt = 0;
  int          cmp_count = 0;
  rfid_reader_model rdr_u (.go(go), .badCrc(badCrc), .mask(mask), .rn(rn16), .hnd(cmdHnd),
    .cmd(toggleCmd));
  rfid_tag_feature_config_control dut_u (.clk_sys(clk_sys), .arst_n(arst_n),
    .tagState(tagState), .sessionHandle(sessionHandle), .rn16(rn16),
    .accessPwZero(accessPwZero), .frameSyncSeen(frameSyncSeen), .reqRnSeen(reqRnSeen),
    .epcBankLocked(epcBankLocked), .memLockEvent(1'b0), .toggleCmd(toggleCmd),
    .memReq(memReq), .tamperPin(tamperPin), .extSupplyPin(extSupplyPin),
    .nvmImage(nvmImage), .nvmWr(nvmWr), .nvmDone(nvmDone), .nvmFail(nvmFail), .reply(reply),
    .memRsp(memRsp), .busy(busy), .cfgWord(cfgWord), .memPartWord(memPartWord),
    .epcBits(epcBits), .openBlocks(openBlocks));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Reader gives up after a bounded wait; commits are acknowledged next cycle
  task automatic waitAns(output logic got);
    got = 1'b0;
    for (int i = 0; i < 40 && !got; i++) begin
      got = reply.valid || memRsp.valid;
      if (!got) begin
        nvmDone = nvmWr.req && !failCommit;
        nvmFail = nvmWr.req && failCommit;
        @(negedge clk_sys);
      end
    end
    nvmDone = 1'b0;
    nvmFail = 1'b0;
  endtask
  // One idle edge first, so go is never lowered and raised in one step
  task automatic toggle(logic [15:0] m, output logic got);
    @(negedge clk_sys);
    mask = m;
    go = 1'b1;
    @(negedge clk_sys);
    go = 1'b0;
    waitAns(got);
  endtask
  task automatic expectWord(logic [15:0] m, logic [15:0] exp);
    logic got;
    toggle(m, got);
    check("toggle reply", {15'h0, got}, 16'h0001);
    check("reply word", reply.word, exp);
    check("reply crc", reply.crc, ~rdr_u.crc16({55'h0, 1'b0, exp, sessionHandle}, 33));
    check("cfg word", cfgWord, exp);
  endtask
  task automatic expectSilent(logic [15:0] m, string what);
    logic got;
    toggle(m, got);
    check(what, {15'h0, got}, 16'h0000);
  endtask
  task automatic memAcc(logic wr, logic [15:0] a, logic [15:0] d);
    logic got;
    @(negedge clk_sys);
    memReq = '{1'b1, wr, a, d};
    @(negedge clk_sys);
    memReq.valid = 1'b0;
    waitAns(got);
    check("mem answer", {15'h0, got}, 16'h0001);
  endtask
  task automatic t_toggle();
    logic got;
    check("cfg after reset", cfgWord, 16'h0003);
    check("busy idle", {15'h0, busy}, 16'h0000);
    expectWord(16'h0002, 16'h0001);
    expectWord(16'h0002, 16'h0003);
    expectWord(16'hc011, 16'h0012);
    check("nvm address", nvmWr.addr, `CFG_ADDR);
    check("nvm data", nvmWr.data, 16'h0012);
    expectWord(16'h0e00, 16'h0e12);
    check("preamble", {15'h0, reply.extPreamble}, 16'h0001);
    failCommit = 1'b1;
    toggle(16'h0002, got);
    check("fail reply", {15'h0, got}, 16'h0001);
    check("fail code", {7'h0, reply.isError, reply.errCode}, 16'h010f);
    check("fail word", cfgWord, 16'h0e12);
    failCommit = 1'b0;
    $display("test toggle done");
  endtask
  task automatic t_refuse();
    expectSilent(16'h1000, "rfu toggle");
    badCrc = 1'b1;
    expectSilent(16'h0002, "bad crc");
    badCrc = 1'b0;
    cmdHnd = ~sessionHandle;
    expectSilent(16'h0002, "bad handle");
    cmdHnd = sessionHandle;
    frameSyncSeen = 1'b0;
    expectSilent(16'h0002, "no frame sync");
    frameSyncSeen = 1'b1;
    reqRnSeen = 1'b0;
    expectSilent(16'h0002, "no req rn");
    reqRnSeen = 1'b1;
    tagState = TAG_ACKNOWLEDGED;
    expectSilent(16'h0002, "wrong state");
    tagState = TAG_OPEN;
    expectWord(16'h0002, 16'h0e12);
    tagState = TAG_SECURED;
    accessPwZero = 1'b1;
    expectWord(16'h0002, 16'h0e12);
    accessPwZero = 1'b0;
    $display("test refuse done");
  endtask
  task automatic t_words();
    tamperPin = 1'b1;
    extSupplyPin = 1'b1;
    memAcc(1'b0, `CFG_ADDR, 16'h0000);
    check("read cfg", memRsp.data, 16'hce12);
    tamperPin = 1'b0;
    extSupplyPin = 1'b0;
    epcBankLocked = 1'b1;
    memAcc(1'b1, `CFG_ADDR, 16'h0012);
    check("locked write", {7'h0, memRsp.error, memRsp.errCode}, 16'h0104);
    epcBankLocked = 1'b0;
    memAcc(1'b1, `CFG_ADDR, 16'hf012);
    check("cfg write", cfgWord, 16'h0012);
    memAcc(1'b0, 16'h0100, 16'h0000);
    check("unmapped", {15'h0, memRsp.hit}, 16'h0000);
    memAcc(1'b1, `MPART_ADDR, 16'h0066);
    check("overbooked", {7'h0, memRsp.error, memRsp.errCode}, 16'h0104);
    memAcc(1'b1, `MPART_ADDR, 16'hf143);
    check("partition", memPartWord, 16'h0143);
    check("nvm mp data", nvmWr.data, 16'h0143);
    check("open blocks", {12'h0, openBlocks}, 16'h0002);
    check("epc bits", {7'h0, epcBits}, 16'h00c0);
    memAcc(1'b1, `MPART_ADDR, 16'h0030);
    check("reprogram", {7'h0, memRsp.error, memRsp.errCode}, 16'h0104);
    check("partition kept", memPartWord, 16'h0143);
    $display("test words done");
  endtask
  initial begin
    #20000;
    error_cnt++;
    $display("watchdog expired");
    final_report();
  end
  initial begin
    arst_n = 1'b0;
    {go, badCrc, accessPwZero, epcBankLocked, tamperPin, extSupplyPin, nvmDone} = '0;
    {nvmFail, failCommit} = '0;
    frameSyncSeen = 1'b1;
    reqRnSeen = 1'b1;
    tagState = TAG_SECURED;
    sessionHandle = 16'h5a3c;
    cmdHnd = 16'h5a3c;
    rn16 = 16'h9c21;
    mask = 16'h0000;
    memReq = '0;
    nvmImage = '{16'h3e03, 16'h0000, 1'b0};
    repeat (12) @(negedge clk_sys);
    arst_n = 1'b1;
    repeat (2) @(negedge clk_sys);
    t_toggle();
    t_refuse();
    t_words();
    final_report();
  end
endmodule // rfid_tag_feature_config_control_test
